// ===== hw/usf_top.sv
// serial status-flag block with its register front end
//
// Overview of operation
// - status read returns flags, then clears them
// - error status is three bits wide, resets zero
// - unit or receive disable zeroes error flags
// - parity mismatch at frame end sets flag
// - missing first stop bit sets framing flag
// - unread holding byte plus new frame: overrun
// - overrun drops new byte, keeps old one
// - transmit status two flags, read-only, resets zero
// - holding buffer write sets holding-full
// - move to shifter or disable clears holding-full
// - busy clears on reset, disable, idle end
// - waiting byte follows current frame without gap
// - busy sets when byte enters shifter
// - any receive error raises error interrupt
// - fixed-zero parity mode never flags parity
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module usf_top (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [usf_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [usf_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // receive shifter
   input wire logic rx_frame_done,
   input wire logic [7:0] rx_frame_data,
   input wire logic rx_parity_bit,
   input wire logic rx_stop_bit,
   // transmit shifter
   input wire logic tx_frame_end,
   output logic tx_load,
   output logic [7:0] tx_load_data,
   // mode and interrupt
   output logic [7:0] serial_mode,
   output logic rx_error_irq
);
   logic awready_reg;
   logic wready_reg;
   logic aw_full;
   logic w_full;
   logic [usf_pkg::ADDR_W-1:0] waddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic [7:0] mode_reg;
   logic wr_exec;
   logic b_done;
   logic rd_acc;
   logic r_done;
   logic [1:0] wr_resp;
   logic [31:0] rd_word;
   logic [1:0] rd_resp;

   usf_flag_if fi ();

   usf_rx_flags u_rx (
      .aclk(aclk),
      .aresetn(aresetn),
      .fi(fi.rx)
   );

   usf_tx_flags u_tx (
      .aclk(aclk),
      .aresetn(aresetn),
      .fi(fi.tx)
   );

   // write byte lane 0 carries every register
   function automatic logic lane_ok(input logic [3:0] strb);
      return strb[0];
   endfunction

   assign wr_exec = aw_full & w_full & ~bvalid_reg;
   assign b_done = bvalid_reg & s_axi_bready;
   assign rd_acc = s_axi_arvalid & arready_reg;
   assign r_done = rvalid_reg & s_axi_rready;

   // mode, shifter and buffer-write signals toward the flag units
   assign fi.unit_en = mode_reg[usf_pkg::MODE_UNIT];
   assign fi.tx_en = mode_reg[usf_pkg::MODE_TX];
   assign fi.rx_en = mode_reg[usf_pkg::MODE_RX];
   assign fi.par_sel = {mode_reg[usf_pkg::MODE_PS_HI], mode_reg[usf_pkg::MODE_PS_LO]};
   assign fi.frame_done = rx_frame_done;
   assign fi.frame_data = rx_frame_data;
   assign fi.par_bit = rx_parity_bit;
   assign fi.stop_bit = rx_stop_bit;
   assign fi.frame_end = tx_frame_end;
   assign fi.txb_data = wdata_q[7:0];
   assign fi.txb_wr = wr_exec & (waddr_q == usf_pkg::OFF_TXB) & lane_ok(wstrb_q);
   // read side effects act in the cycle the address is taken
   assign fi.status_rd = rd_acc & (s_axi_araddr == usf_pkg::OFF_RX_ERR);
   assign fi.rxb_rd = rd_acc & (s_axi_araddr == usf_pkg::OFF_RXB);

   // outputs
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   assign serial_mode = mode_reg;
   assign tx_load = fi.load;
   assign tx_load_data = fi.load_data;
   assign rx_error_irq = fi.err_pulse;

   // write address channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b1;
         aw_full <= 1'b0;
         waddr_q <= '0;
      end else begin
         if (s_axi_awvalid && awready_reg) begin
            waddr_q <= s_axi_awaddr;
            aw_full <= 1'b1;
            awready_reg <= 1'b0;
         end
         if (wr_exec) begin
            aw_full <= 1'b0;
         end
         if (b_done) begin
            awready_reg <= 1'b1;
         end
      end
   end

   // write data channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_reg <= 1'b1;
         w_full <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (s_axi_wvalid && wready_reg) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_full <= 1'b1;
            wready_reg <= 1'b0;
         end
         if (wr_exec) begin
            w_full <= 1'b0;
         end
         if (b_done) begin
            wready_reg <= 1'b1;
         end
      end
   end

   // only mode and transmit buffer take writes
   always_comb begin
      wr_resp = usf_pkg::RESP_SLVERR;
      if ((waddr_q == usf_pkg::OFF_MODE || waddr_q == usf_pkg::OFF_TXB) &&
          lane_ok(wstrb_q)) begin
         wr_resp = usf_pkg::RESP_OKAY;
      end
   end

   // write response channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= usf_pkg::RESP_OKAY;
      end else if (wr_exec) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_resp;
      end else if (b_done) begin
         bvalid_reg <= 1'b0;
      end
   end

   // mode register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_reg <= usf_pkg::MODE_RST;
      end else if (wr_exec && waddr_q == usf_pkg::OFF_MODE && lane_ok(wstrb_q)) begin
         mode_reg <= wdata_q[7:0];
      end
   end

   // read decode, upper bits read as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_resp = usf_pkg::RESP_OKAY;
      case (s_axi_araddr)
         usf_pkg::OFF_RX_ERR: begin
            rd_word[2:0] = fi.err_flags;
         end
         usf_pkg::OFF_TX_STAT: begin
            rd_word[usf_pkg::TXBF_BIT] = fi.hold_full;
            rd_word[usf_pkg::TXSF_BIT] = fi.shift_busy;
         end
         usf_pkg::OFF_MODE: begin
            rd_word[7:0] = mode_reg;
         end
         usf_pkg::OFF_TXB: begin
            rd_word[7:0] = 8'h00;
         end
         usf_pkg::OFF_RXB: begin
            rd_word[7:0] = fi.rxb;
         end
         default: begin
            rd_resp = usf_pkg::RESP_SLVERR;
         end
      endcase
   end

   // read channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rresp_reg <= usf_pkg::RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
      end else if (rd_acc) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= rd_resp;
         rdata_reg <= rd_word;
      end else if (r_done) begin
         rvalid_reg <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   write_resp_a: assert property (wr_exec |=> bvalid_reg && !awready_reg && !wready_reg)
      else $error("write response not raised after address and data");
   read_resp_a: assert property (rd_acc |=> rvalid_reg && !arready_reg)
      else $error("read data not raised after address");
   status_width_a: assert property (rd_acc && s_axi_araddr == usf_pkg::OFF_RX_ERR
      |=> rdata_reg[31:3] == 29'h0 && rdata_reg[2:0] == $past(fi.err_flags))
      else $error("error status read wrong");
   status_clear_a: assert property (rd_acc && s_axi_araddr == usf_pkg::OFF_RX_ERR
      && !rx_frame_done |=> fi.err_flags == 3'h0)
      else $error("error status not cleared by read");
   tx_status_a: assert property (rd_acc && s_axi_araddr == usf_pkg::OFF_TX_STAT
      |=> rdata_reg == {30'h0, $past(fi.hold_full), $past(fi.shift_busy)})
      else $error("transmit status read wrong");
   mode_write_a: assert property (wr_exec && waddr_q == usf_pkg::OFF_MODE && wstrb_q[0]
      |=> mode_reg == $past(wdata_q[7:0]))
      else $error("mode register write lost");
   lane_refused_a: assert property (wr_exec && !wstrb_q[0]
      |=> bresp_reg == usf_pkg::RESP_SLVERR && $stable(mode_reg))
      else $error("write without byte lane 0 not refused");
   write_gate_a: assert property (!awready_reg && !b_done
      |=> !awready_reg && !wready_reg)
      else $error("write channels reopened before response");
   write_reopen_a: assert property (b_done
      |=> awready_reg && wready_reg && !bvalid_reg)
      else $error("write channels not reopened after response");
   read_reopen_a: assert property (r_done
      |=> arready_reg && !rvalid_reg)
      else $error("read channel not reopened after data");
   unmapped_read_a: assert property (rd_acc && s_axi_araddr > usf_pkg::OFF_RXB
      |=> rresp_reg == usf_pkg::RESP_SLVERR && rdata_reg == 32'h0000_0000)
      else $error("unmapped read not refused");
   load_flags_a: assert property (tx_load && !$past(fi.txb_wr)
      |-> !fi.hold_full && fi.shift_busy)
      else $error("flags wrong while byte enters shifter");
   rx_off_irq_a: assert property (!fi.rx_en && rx_frame_done
      |=> !rx_error_irq)
      else $error("error interrupt raised while reception disabled");

   overrun_c: cover property (fi.err_flags[usf_pkg::OV_BIT] && rd_acc);
   back_to_back_c: cover property (fi.shift_busy && fi.hold_full ##[1:1000] tx_load);
   error_irq_c: cover property (rx_error_irq);
   write_then_read_c: cover property (b_done ##[1:20] r_done);
   refused_write_c: cover property (wr_exec && !wstrb_q[0]);
endmodule // usf_top

// ===== hw/usf_pkg.sv
// shared constants of the serial status-flag block
package usf_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_RX_ERR = 8'h00;
   localparam logic [7:0] OFF_TX_STAT = 8'h04;
   localparam logic [7:0] OFF_MODE = 8'h08;
   localparam logic [7:0] OFF_TXB = 8'h0C;
   localparam logic [7:0] OFF_RXB = 8'h10;
   localparam int PE_BIT = 2;
   localparam int FE_BIT = 1;
   localparam int OV_BIT = 0;
   localparam int TXBF_BIT = 1;
   localparam int TXSF_BIT = 0;
   localparam int MODE_UNIT = 7;
   localparam int MODE_TX = 6;
   localparam int MODE_RX = 5;
   localparam int MODE_PS_HI = 4;
   localparam int MODE_PS_LO = 3;
   localparam logic [7:0] MODE_RST = 8'h01;
   localparam logic [2:0] ERR_RST = 3'h0;
   localparam logic [7:0] BUF_RST = 8'hFF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hw/usf_flag_if.sv
// signals between the register front end and the two flag units
`timescale 1ns/1ps
interface usf_flag_if;
   logic unit_en;
   logic rx_en;
   logic tx_en;
   logic [1:0] par_sel;
   logic frame_done;
   logic [7:0] frame_data;
   logic par_bit;
   logic stop_bit;
   logic status_rd;
   logic rxb_rd;
   logic [2:0] err_flags;
   logic [7:0] rxb;
   logic err_pulse;
   logic txb_wr;
   logic [7:0] txb_data;
   logic frame_end;
   logic hold_full;
   logic shift_busy;
   logic load;
   logic [7:0] load_data;
   modport ctl(output unit_en, rx_en, tx_en, par_sel, frame_done, frame_data, par_bit,
      stop_bit, status_rd, rxb_rd, txb_wr, txb_data, frame_end,
      input err_flags, rxb, err_pulse, hold_full, shift_busy, load, load_data);
   modport rx(input unit_en, rx_en, par_sel, frame_done, frame_data, par_bit, stop_bit,
      status_rd, rxb_rd, output err_flags, rxb, err_pulse);
   modport tx(input unit_en, tx_en, txb_wr, txb_data, frame_end,
      output hold_full, shift_busy, load, load_data);
endinterface

// ===== hw/usf_rx_flags.sv
// receive error flags and receive holding buffer
`timescale 1ns/1ps
module usf_rx_flags (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // front end
   usf_flag_if.rx fi
);
   logic en;
   logic done;
   logic unread;
   logic [2:0] hits;
   logic [2:0] err_reg;
   logic [7:0] rxb_reg;
   logic irq_reg;
   assign en = fi.unit_en & fi.rx_en;
   assign done = fi.frame_done & en;
   assign fi.err_flags = err_reg;
   assign fi.rxb = rxb_reg;
   assign fi.err_pulse = irq_reg;
   always_comb begin
      hits = '0;
      // fixed-zero and no-parity modes never
      hits[usf_pkg::PE_BIT] = fi.par_sel[1] &
         (fi.par_bit != ((^fi.frame_data) ^ ~fi.par_sel[0]));
      hits[usf_pkg::FE_BIT] = ~fi.stop_bit;
      hits[usf_pkg::OV_BIT] = unread & ~fi.rxb_rd;
   end
   // flags update at frame completion, a new error beats the read clear
   always_ff @(posedge aclk) begin
      if (!aresetn || !en) begin
         err_reg <= usf_pkg::ERR_RST;
      end else begin
         err_reg <= (err_reg & ~{3{fi.status_rd}}) | (hits & {3{done}});
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || !fi.unit_en) begin
         rxb_reg <= usf_pkg::BUF_RST;
         unread <= 1'b0;
      end else if (done && !hits[usf_pkg::OV_BIT]) begin
         rxb_reg <= fi.frame_data;
         unread <= 1'b1;
      end else if (fi.rxb_rd) begin
         unread <= 1'b0; // overrun keeps older byte
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= done & (|hits);
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   read_clears_a: assert property (fi.status_rd && !done |=> err_reg == 3'h0)
      else $error("error flags not cleared by status read");
   disable_clears_a: assert property (!en |=> err_reg == 3'h0)
      else $error("error flags survive disable");
   overrun_keep_a: assert property (done && unread && !fi.rxb_rd |=>
      $stable(rxb_reg) && err_reg[usf_pkg::OV_BIT]) else $error("overrun mishandled");
   framing_set_a: assert property (done && !fi.stop_bit |=> err_reg[usf_pkg::FE_BIT])
      else $error("framing flag missing");
   no_parity_a: assert property (!fi.par_sel[1] && !err_reg[usf_pkg::PE_BIT]
      |=> !err_reg[usf_pkg::PE_BIT]) else $error("parity flag set without check");
   irq_pulse_a: assert property (done && (|hits) |=>
      irq_reg ##1 (!irq_reg || $past(done && (|hits))))
      else $error("error interrupt not raised");
endmodule // usf_rx_flags

// ===== hw/usf_tx_flags.sv
// transmit holding-full and shifter-busy flags
`timescale 1ns/1ps
module usf_tx_flags (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // front end
   usf_flag_if.tx fi
);
   logic en;
   logic move;
   logic full_reg;
   logic busy_reg;
   logic load_reg;
   logic [7:0] hold_reg;
   logic [7:0] load_data_reg;
   assign en = fi.unit_en & fi.tx_en;
   // waiting byte goes out right behind the current frame
   assign move = en & full_reg & (~busy_reg | fi.frame_end);
   assign fi.hold_full = full_reg;
   assign fi.shift_busy = busy_reg;
   assign fi.load = load_reg;
   assign fi.load_data = load_data_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn || !en) begin
         full_reg <= 1'b0;
      end else if (fi.txb_wr) begin
         full_reg <= 1'b1;
      end else if (move) begin
         full_reg <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_reg <= usf_pkg::BUF_RST;
      end else if (fi.txb_wr && en) begin
         hold_reg <= fi.txb_data;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || !en) begin
         busy_reg <= 1'b0;
      end else if (move) begin
         busy_reg <= 1'b1;
      end else if (fi.frame_end) begin
         busy_reg <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         load_reg <= 1'b0;
         load_data_reg <= usf_pkg::BUF_RST;
      end else begin
         load_reg <= move;
         if (move) begin
            load_data_reg <= hold_reg;
         end
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   hold_set_a: assert property (fi.txb_wr && en |=> full_reg)
      else $error("holding-full flag not set by write");
   move_load_a: assert property (move && !fi.txb_wr |=>
      load_reg && busy_reg && !full_reg) else $error("byte not moved to shifter");
   busy_drop_a: assert property (en && fi.frame_end && !full_reg |=> !busy_reg)
      else $error("busy flag held after last frame");
   disable_idle_a: assert property (!en |=> !busy_reg && !full_reg)
      else $error("transmit flags survive disable");
endmodule // usf_tx_flags

// ===== testbench/usf_shifter_model.sv
// behavioural receive and transmit shifters facing the flag block
`timescale 1ns/1ps
module usf_shifter_model #(
   parameter int FRAME = 20
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tx_load,
   input wire logic [7:0] tx_load_data,
   output logic rx_frame_done,
   output logic [7:0] rx_frame_data,
   output logic rx_parity_bit,
   output logic rx_stop_bit,
   output logic tx_frame_end,
   output logic [7:0] loads,
   output logic [7:0] last_byte,
   output logic [7:0] gap
);
   logic [7:0] cnt;
   logic [7:0] since;
   initial begin
      rx_frame_done = 1'b0;
      rx_frame_data = 8'h00;
      rx_parity_bit = 1'b0;
      rx_stop_bit = 1'b1;
   end
   // one frame of receive data; lines show the inverse once released
   task automatic rx_frame(input logic [7:0] d, input logic p, input logic s);
      @(posedge aclk);
      rx_frame_done <= 1'b1;
      rx_frame_data <= d;
      rx_parity_bit <= p;
      rx_stop_bit <= s;
      @(posedge aclk);
      rx_frame_done <= 1'b0;
      rx_frame_data <= ~d;
      rx_parity_bit <= ~p;
      rx_stop_bit <= ~s;
   endtask
   // transmit frame lasts FRAME cycles from each load
   always_ff @(posedge aclk) begin
      tx_frame_end <= 1'b0;
      since <= tx_frame_end ? 8'h01 : since + 8'h01;
      if (!aresetn) begin
         cnt <= 8'h00;
         loads <= 8'h00;
         last_byte <= 8'h00;
         gap <= 8'h00;
      end else if (tx_load) begin
         cnt <= 8'(FRAME);
         loads <= loads + 8'h01;
         last_byte <= tx_load_data;
         gap <= since;
      end else if (cnt == 8'h01) begin
         cnt <= 8'h00;
         tx_frame_end <= 1'b1;
      end else if (cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
      end
   end
endmodule // usf_shifter_model

// ===== testbench/usf_top_tb.sv
// self-checking bench of the serial status-flag block
`timescale 1ns/1ps
module usf_top_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq, done, par, stop, fend, load;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, d;
   logic [7:0] fdata, ldata, mode, loads, lastb, gap;
   int n_fail = 0, n_checks = 0, irq_n = 0, exp_irq = 0, i;
   logic [1:0] ps;
   logic p, pe;
   always #2.5 aclk = ~aclk;
   always @(posedge aclk) if (irq === 1'b1) irq_n++;
   usf_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .rx_frame_done(done), .rx_frame_data(fdata),
      .rx_parity_bit(par), .rx_stop_bit(stop), .tx_frame_end(fend), .tx_load(load),
      .tx_load_data(ldata), .serial_mode(mode), .rx_error_irq(irq));
   usf_shifter_model #(.FRAME(20)) model_u (.aclk(aclk), .aresetn(aresetn),
      .tx_load(load), .tx_load_data(ldata), .rx_frame_done(done), .rx_frame_data(fdata),
      .rx_parity_bit(par), .rx_stop_bit(stop), .tx_frame_end(fend), .loads(loads),
      .last_byte(lastb), .gap(gap));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
      logic ap, wp, bp;
      ap = 1'b1;
      wp = 1'b1;
      bp = 1'b1;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h00_0000, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (ap | wp | bp) begin
         @(posedge aclk);
         if (ap && awready === 1'b1) begin ap = 1'b0; awvalid <= 1'b0; end
         if (wp && wready === 1'b1) begin wp = 1'b0; wvalid <= 1'b0; end
         if (bp && bvalid === 1'b1) begin bp = 1'b0; r = bresp; bready <= 1'b0; end
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      logic ap, rp;
      ap = 1'b1;
      rp = 1'b1;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (ap | rp) begin
         @(posedge aclk);
         if (ap && arready === 1'b1) begin ap = 1'b0; arvalid <= 1'b0; end
         if (rp && rvalid === 1'b1) begin rp = 1'b0; v = rdata; r = rresp; rready <= 1'b0; end
      end
   endtask
   task automatic wc(input logic [7:0] a, input logic [7:0] v, input logic [1:0] e);
      logic [1:0] r;
      wr(a, v, r);
      chk({30'h0, r}, {30'h0, e});
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] v;
      logic [1:0] r;
      rd(a, v, r);
      chk(v, {24'h00_0000, e});
   endtask
   task automatic wrap_up();
      if (n_fail == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #100_000;
      n_fail++;
      wrap_up();
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rc(usf_pkg::OFF_RX_ERR, 8'h00);
      rc(usf_pkg::OFF_TX_STAT, 8'h00);
      rc(usf_pkg::OFF_RXB, 8'hFF);
      chk({24'h00_0000, mode}, {24'h00_0000, usf_pkg::MODE_RST});
      wc(usf_pkg::OFF_RX_ERR, 8'h07, usf_pkg::RESP_SLVERR);
      wc(usf_pkg::OFF_TX_STAT, 8'h03, usf_pkg::RESP_SLVERR);
      rd(8'h20, d, resp);
      chk({30'h0, resp}, {30'h0, usf_pkg::RESP_SLVERR});
      // every parity mode with both parity bit values, data 0x01
      for (i = 0; i < 8; i++) begin
         ps = i[2:1];
         p = i[0];
         pe = ps[1] & (p != ps[0]);
         exp_irq += pe;
         wc(usf_pkg::OFF_MODE, {3'b111, ps, 3'b000}, usf_pkg::RESP_OKAY);
         model_u.rx_frame(8'h01, p, 1'b1);
         rc(usf_pkg::OFF_RX_ERR, {5'h00, pe, 2'b00});
         rc(usf_pkg::OFF_RXB, 8'h01);
      end
      chk(irq_n, exp_irq);
      model_u.rx_frame(8'hA5, 1'b1, 1'b0);
      rc(usf_pkg::OFF_RX_ERR, 8'h06);
      rc(usf_pkg::OFF_RX_ERR, 8'h00);
      rc(usf_pkg::OFF_RXB, 8'hA5);
      model_u.rx_frame(8'h11, 1'b0, 1'b1);
      model_u.rx_frame(8'h22, 1'b0, 1'b1);
      rc(usf_pkg::OFF_RX_ERR, 8'h01);
      rc(usf_pkg::OFF_RXB, 8'h11);
      chk(irq_n, exp_irq + 2);
      model_u.rx_frame(8'h33, 1'b0, 1'b0);
      wc(usf_pkg::OFF_MODE, 8'hC0, usf_pkg::RESP_OKAY);
      rc(usf_pkg::OFF_RX_ERR, 8'h00);
      model_u.rx_frame(8'h44, 1'b1, 1'b0);
      rc(usf_pkg::OFF_RX_ERR, 8'h00);
      chk(irq_n, exp_irq + 3);
      // refused mode write without byte lane 0, back-to-back transmission, transmit disable
      wc(usf_pkg::OFF_MODE, 8'hE0, usf_pkg::RESP_OKAY);
      chk({24'h00_0000, mode}, 32'h0000_00E0);
      wstrb <= 4'hE;
      wc(usf_pkg::OFF_MODE, 8'h00, usf_pkg::RESP_SLVERR);
      wstrb <= 4'hF;
      rc(usf_pkg::OFF_MODE, 8'hE0);
      chk({24'h00_0000, mode}, 32'h0000_00E0);
      wc(usf_pkg::OFF_TXB, 8'h3C, usf_pkg::RESP_OKAY);
      rc(usf_pkg::OFF_TX_STAT, 8'h01);
      wc(usf_pkg::OFF_TXB, 8'hC3, usf_pkg::RESP_OKAY);
      rc(usf_pkg::OFF_TX_STAT, 8'h03);
      chk({24'h00_0000, lastb}, 32'h0000_003C);
      for (i = 0; i < 100; i++) begin
         rd(usf_pkg::OFF_TX_STAT, d, resp);
         if (d === 32'h0000_0000) break;
      end
      rc(usf_pkg::OFF_TX_STAT, 8'h00);
      chk({24'h00_0000, gap}, 32'h0000_0001);
      chk({24'h00_0000, loads}, 32'h0000_0002);
      chk({24'h00_0000, lastb}, 32'h0000_00C3);
      wc(usf_pkg::OFF_TXB, 8'h55, usf_pkg::RESP_OKAY);
      wc(usf_pkg::OFF_TXB, 8'h66, usf_pkg::RESP_OKAY);
      wc(usf_pkg::OFF_MODE, 8'hA0, usf_pkg::RESP_OKAY);
      rc(usf_pkg::OFF_TX_STAT, 8'h00);
      wrap_up();
   end
endmodule // usf_top_tb
